// >>> hw/nct_controller.sv
// Purpose: Nonvolatile memory command and trigger controller
// Assumes: Requests arrive on clk; access ports are one-cycle strobes
// Notes:   Registers are plain ports; sequencer does the array work
//          Reads, writes and matching execute bits during busy are refused, never queued
// Summary of operation
// - Command-execute bit starts action commands
// - Memory read starts read commands
// - Memory write starts write commands
// - Self-programming triggers need change protection gate
// - Busy flag set while operation runs
// - Register writes ignored while busy
// - Programming blocks other programming
// - Programming refuses page buffer load/erase
// - Programming blocks external and application reads
// - External programmer: all but production row writable
// - Self-programming privileges limited, locks only tighten
// - Separate locks per section and requester
// - Checksum over whole flash or range
// - Processor keeps fetching during flash programming, except while writing the boot section
module nct_controller
  import nct_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Register writes (one-cycle strobes)
  input  wire logic              cmd_wr,
  input  wire logic [CMD_W-1:0]  cmd_wdata,
  input  wire logic              addr_wr,
  input  wire logic [ADDR_W-1:0] addr_wdata,
  input  wire logic              data_wr,
  input  wire logic [DATA_W-1:0] data_wdata,
  input  wire logic              command_execute_bit,
  input  wire logic              ctrl_b_wr,
  input  wire logic [ADDR_W-1:0] ctrl_b_wdata,
  input  wire logic              lock_wr,
  input  wire logic [11:0]       lock_wdata,
  // Requester identity and protection
  input  wire logic              ext_prog,
  input  wire logic              change_protection_gate,
  input  wire logic              from_boot,
  input  wire logic [1:0]        section,
  // Memory access triggers
  input  wire logic              nvm_read,
  input  wire logic              nvm_write,
  // Memory array port
  output logic                   mem_req,
  output logic                   mem_we,
  output logic [ADDR_W-1:0]      mem_addr,
  output logic [DATA_W-1:0]      mem_wdata,
  input  wire logic              mem_ack,
  input  wire logic [15:0]       mem_rword,
  // Status
  output logic                   busy,
  output logic                   refused,
  output logic                   cpu_fetch_ok,
  output logic [CMD_W-1:0]       cmd_reg,
  output logic [CRC_W-1:0]       crc_result,
  output logic [11:0]            lock_bits
);
  // Operation channel toward the sequencer; the sequencer owns busy,
  // so the register freeze and the start gate see one and the same flag
  nct_op_if op ();

  // Requester-visible registers and their next values
  logic [CMD_W-1:0]  cmd,  next_cmd;    // Command register
  logic [ADDR_W-1:0] addr, next_addr;   // Address register
  logic [DATA_W-1:0] data, next_data;   // Data register
  logic [ADDR_W-1:0] cend, next_cend;   // Control B: checksum end
  logic [11:0]       lock, next_lock;   // {ext, boot, table, app} x2 bits
  logic              rej,  next_rej;    // Refusal pulse
  logic              go;                // Start request this cycle
  logic              allowed;           // Privilege check result
  nct_trig_t         kind;              // Trigger kind of command

  // Lock layout: one pair per section for self-programming, low bits
  // first, and a single pair for the external programmer on top.
  // A cleared bit closes the path; reset leaves every path open.
  // Two lock bits for the requester and section in question
  function automatic logic [1:0] lock_of(input logic [11:0] l,
                                         input logic e,
                                         input logic [1:0] s);
    logic [1:0] r;
    r = e ? l[11:10] : l[2*s +: 2];
    return r;
  endfunction

  // Trigger kind lives in the top bits of the held command, so a
  // command write alone never starts anything: the event must follow
  assign kind = nct_trig_t'(cmd[TRIG_HI:TRIG_LO]);

  // Privilege check against requester and section locks
  // Order matters: the requester rule is settled first, then the
  // section lock may only narrow the result, never widen it
  always_comb begin
    logic [1:0] lk;
    lk      = lock_of(lock, ext_prog, section);
    allowed = 1'b1;
    if (ext_prog) begin
      allowed = (cmd != CMD_WRITE_PSIG);
    end else if (!change_protection_gate) begin
      allowed = 1'b0;
    end else begin
      // Application code only reads flash; boot code may write
      case (cmd)
        CMD_WRITE_PSIG: allowed = 1'b0;
        CMD_WRITE_MEM, CMD_WRITE_USIG, CMD_WRITE_LOCK:
          allowed = from_boot;
        default: allowed = 1'b1;
      endcase
    end
    // Section lock: read path and write path are closed separately
    if (kind == NCT_TRIG_READ && !lk[LOCK_R_BIT]) begin
      allowed = 1'b0;
    end
    if (kind == NCT_TRIG_WRITE && !lk[LOCK_W_BIT]) begin
      allowed = 1'b0;
    end
  end

  // Trigger decode: only the matching event starts the command
  // An event of the wrong kind is not a refusal when idle: a plain read while a
  // write command is held simply passes by the controller
  always_comb begin
    go = 1'b0;
    case (kind)
      NCT_TRIG_ACTION: go = command_execute_bit;
      NCT_TRIG_READ:   go = nvm_read;
      NCT_TRIG_WRITE:  go = nvm_write;
      default:         go = 1'b0;
    endcase
  end

  // Register next values; everything frozen while busy
  // Writes that arrive while busy are dropped, not queued: the
  // requester has to repeat them once busy has fallen.
  // Refusal is reported one cycle late, as a single-cycle pulse
  always_comb begin
    next_cmd  = cmd;
    next_addr = addr;
    next_data = data;
    next_cend = cend;
    next_lock = lock;
    next_rej  = 1'b0;
    if (!op.busy) begin
      if (cmd_wr) begin
        next_cmd = cmd_wdata;
      end
      if (addr_wr) begin
        next_addr = addr_wdata;
      end
      if (data_wr) begin
        next_data = data_wdata;
      end
      if (ctrl_b_wr) begin
        next_cend = ctrl_b_wdata;
      end
      if (lock_wr) begin
        // Self-programming may only clear lock bits (tighten)
        next_lock = ext_prog ? lock_wdata : (lock & lock_wdata);
      end
    end
    // Busy: any array access, and the execute bit under an action command, is refused; nothing starts
    // A refused trigger leaves every register as it was
    if (op.busy && (go || nvm_read || nvm_write)) begin
      next_rej = 1'b1;
    end else if (go && !allowed) begin
      next_rej = 1'b1;
    end
  end

  // Register state
  // Synchronous reset; locks come back fully open
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cmd  <= CMD_NOP;
      addr <= '0;
      data <= '0;
      cend <= '0;
      lock <= {6{LOCK_RESET}};
      rej  <= 1'b0;
    end else begin
      cmd  <= next_cmd;
      addr <= next_addr;
      data <= next_data;
      cend <= next_cend;
      lock <= next_lock;
      rej  <= next_rej;
    end
  end

  // Start only when idle and permitted
  // Start is combinational so busy rises on the very next edge;
  // the held command, address and data feed the sequencer directly
  assign op.start = go && allowed && !op.busy;
  assign op.cmd   = cmd;
  assign op.addr  = addr;
  assign op.data  = data;

  // Operation sequencer: checksum walk and array handshake
  // It alone talks to the array; the controller never waits on it
  nct_sequencer u_seq (
    .clk       (clk),
    .rstn      (rstn),
    .op        (op),
    .crc_end   (cend),
    .mem_req   (mem_req),
    .mem_we    (mem_we),
    .mem_addr  (mem_addr),
    .mem_wdata (mem_wdata),
    .mem_ack   (mem_ack),
    .mem_rword (mem_rword)
  );

  // Status outputs
  // The fetch flag is a coarse view: only a write into the boot
  // section, where the loader runs, stalls the processor
  assign busy       = op.busy;
  assign refused    = rej;
  // Fetch stays open unless the write targets the boot section
  assign cpu_fetch_ok = !(mem_we && section == SEC_BOOT);
  assign cmd_reg    = cmd;
  assign crc_result = op.crc;
  assign lock_bits  = lock;
endmodule

// >>> common/nct_pkg.sv
// Purpose: Shared constants and types for the memory command trigger block
// Assumes: 20 MHz system clock, synchronous active-low reset
// Notes:   Command codes and lock encodings are local choices
package nct_pkg;
  // Command register width and data/address widths
  localparam int CMD_W  = 7;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 8;
  localparam int CRC_W  = 24;

  // Trigger kinds carried in the two top bits of a command code
  typedef enum logic [1:0] {
    NCT_TRIG_NONE   = 2'h0,
    NCT_TRIG_ACTION = 2'h1,
    NCT_TRIG_READ   = 2'h2,
    NCT_TRIG_WRITE  = 2'h3
  } nct_trig_t;

  // Command codes: {trigger kind, operation}
  localparam logic [CMD_W-1:0] CMD_NOP        = 7'h00;
  localparam logic [CMD_W-1:0] CMD_CRC_FLASH  = 7'h20;
  localparam logic [CMD_W-1:0] CMD_CRC_RANGE  = 7'h21;
  localparam logic [CMD_W-1:0] CMD_READ_MEM   = 7'h40;
  localparam logic [CMD_W-1:0] CMD_READ_PSIG  = 7'h41;
  localparam logic [CMD_W-1:0] CMD_READ_FUSE  = 7'h42;
  localparam logic [CMD_W-1:0] CMD_WRITE_MEM  = 7'h60;
  localparam logic [CMD_W-1:0] CMD_WRITE_USIG = 7'h61;
  localparam logic [CMD_W-1:0] CMD_WRITE_PSIG = 7'h62;
  localparam logic [CMD_W-1:0] CMD_WRITE_LOCK = 7'h63;
  localparam logic [CMD_W-1:0] CMD_LOAD_BUF   = 7'h64;
  localparam logic [CMD_W-1:0] CMD_ERASE_BUF  = 7'h65;

  // Field of the command code holding the trigger kind
  localparam int TRIG_HI = 6;
  localparam int TRIG_LO = 5;

  // Section select for lock lookup
  localparam logic [1:0] SEC_APP   = 2'h0;
  localparam logic [1:0] SEC_TABLE = 2'h1;
  localparam logic [1:0] SEC_BOOT  = 2'h2;

  // Lock field: bit0 blocks write, bit1 blocks read (0 = locked)
  localparam int LOCK_W_BIT = 0;
  localparam int LOCK_R_BIT = 1;
  localparam logic [1:0] LOCK_RESET = 2'h3;

  // CRC polynomial x^24+x^4+x^3+x+1, seed zero
  localparam logic [CRC_W-1:0] CRC_POLY = 24'h00001B;
  localparam logic [CRC_W-1:0] CRC_SEED = 24'h000000;

  // Operation length in cycles, OP_TIME_NS over CLK_NS rounded up
  localparam int OP_TIME_NS = 1000;
  localparam int CLK_NS     = 50;
  localparam int OP_CYCLES  = (OP_TIME_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> common/nct_op_if.sv
// Purpose: Carries one started operation to the sequencer
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse, done marks completion
interface nct_op_if;
  import nct_pkg::*;
  logic              start;  // One-cycle request
  logic [CMD_W-1:0]  cmd;    // Latched command
  logic [ADDR_W-1:0] addr;   // Latched address
  logic [DATA_W-1:0] data;   // Latched data
  logic              busy;   // Sequencer running
  logic              done;   // One-cycle completion
  logic [CRC_W-1:0]  crc;    // Last checksum
  modport ctl (output start, cmd, addr, data, input busy, done, crc);
  modport seq (input start, cmd, addr, data, output busy, done, crc);
endinterface

// >>> hw/nct_sequencer.sv
// Purpose: Runs one memory operation and the checksum walk
// Assumes: Memory array answers mem_ack within any number of cycles
// Notes:   Busy rises the cycle after start and falls with done
module nct_sequencer
  import nct_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  rstn,
  // Operation channel
  nct_op_if.seq      op,
  // Checksum range end (inclusive word address)
  input  wire logic [ADDR_W-1:0] crc_end,
  // Memory array port
  output logic              mem_req,
  output logic              mem_we,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  input  wire logic         mem_ack,
  input  wire logic [15:0]  mem_rword
);
  // One-hot sequencer states
  typedef enum logic [2:0] {
    NCT_S_IDLE = 3'h1,
    NCT_S_MEM  = 3'h2,
    NCT_S_CRC  = 3'h4
  } nct_seq_t;

  nct_seq_t          state, next_state;     // Sequencer state
  logic [ADDR_W-1:0] cur,   next_cur;       // Walking address
  logic [CRC_W-1:0]  crc,   next_crc;       // Signature register
  logic              done,  next_done;      // Completion pulse
  logic              we,    next_we;        // Write direction

  // One signature step over a 16-bit word
  function automatic logic [CRC_W-1:0] misr(input logic [CRC_W-1:0] s,
                                            input logic [15:0] d);
    logic [CRC_W-1:0] t;
    t = {s[CRC_W-2:0], 1'b0} ^ (s[CRC_W-1] ? CRC_POLY : CRC_SEED);
    return t ^ {{(CRC_W-16){1'b0}}, d};
  endfunction

  // Next-state logic
  always_comb begin
    next_state = state;
    next_cur   = cur;
    next_crc   = crc;
    next_done  = 1'b0;
    next_we    = we;
    case (state)
      NCT_S_IDLE: begin
        if (op.start) begin
          next_cur = op.addr;
          next_we  = (op.cmd[TRIG_HI:TRIG_LO] == NCT_TRIG_WRITE);
          if (op.cmd[TRIG_HI:TRIG_LO] == NCT_TRIG_ACTION) begin
            // Whole flash starts at zero, range starts at address
            if (op.cmd == CMD_CRC_FLASH) begin
              next_cur = '0;
            end
            next_crc   = CRC_SEED;
            next_state = NCT_S_CRC;
          end else begin
            next_state = NCT_S_MEM;
          end
        end
      end
      NCT_S_MEM: begin
        // Busy holds until the array confirms
        if (mem_ack) begin
          next_done  = 1'b1;
          next_state = NCT_S_IDLE;
        end
      end
      NCT_S_CRC: begin
        // Whole words only: an odd range reads one extra byte
        if (mem_ack) begin
          next_crc = misr(crc, mem_rword);
          next_cur = cur + ADDR_W'(2);
          if (cur >= crc_end) begin
            next_done  = 1'b1;
            next_state = NCT_S_IDLE;
          end
        end
      end
      default: next_state = NCT_S_IDLE;
    endcase
  end

  // State registers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= NCT_S_IDLE;
      cur   <= '0;
      crc   <= CRC_SEED;
      done  <= 1'b0;
      we    <= 1'b0;
    end else begin
      state <= next_state;
      cur   <= next_cur;
      crc   <= next_crc;
      done  <= next_done;
      we    <= next_we;
    end
  end

  // Outputs toward the controller and the array
  assign op.busy   = (state != NCT_S_IDLE);
  assign op.done   = done;
  assign op.crc    = crc;
  assign mem_req   = (state != NCT_S_IDLE);
  assign mem_we    = we && (state == NCT_S_MEM);
  assign mem_addr  = cur;
  assign mem_wdata = op.data;
endmodule

// >>> test/nct_controller_props.sv
// Purpose: Timing and privilege properties of the command controller
// Assumes: Sees only top ports; one clock, sync active-low reset
// Notes:   Bound from the testbench top file
module nct_props
  import nct_pkg::*;
(
  // Clock and reset
  input wire logic             clk,
  input wire logic             rstn,
  // Requests
  input wire logic             cmd_wr,
  input wire logic             command_execute_bit,
  input wire logic             nvm_read,
  input wire logic             nvm_write,
  input wire logic             lock_wr,
  input wire logic             ext_prog,
  input wire logic             change_protection_gate,
  input wire logic             mem_ack,
  // Status
  input wire logic             busy,
  input wire logic             refused,
  input wire logic             mem_req,
  input wire logic [CMD_W-1:0] cmd_reg,
  input wire logic [11:0]      lock_bits
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Trigger kind of the held command
  wire logic [1:0] kind = cmd_reg[TRIG_HI:TRIG_LO];

  rose_cause_a: assert property ($rose(busy) |->
    $past(command_execute_bit || nvm_read || nvm_write))
    else $error("busy rose with no trigger");
  busy_end_a: assert property ($fell(busy) |-> $past(mem_ack))
    else $error("busy fell before completion");
  req_busy_a: assert property (mem_req |-> busy)
    else $error("memory request outside busy");
  cmd_stable_a: assert property (busy && cmd_wr |=> $stable(cmd_reg))
    else $error("command changed while busy");
  write_block_a: assert property (busy && nvm_write && kind == 2'h3
    |=> refused) else $error("write trigger taken while busy");
  read_block_a: assert property (busy && nvm_read && kind == 2'h2
    |=> refused) else $error("read trigger taken while busy");
  psig_ro_a: assert property (!busy && nvm_write && ext_prog &&
    cmd_reg == CMD_WRITE_PSIG |=> refused && !busy)
    else $error("signature row write accepted");
  gate_need_a: assert property (!busy && !ext_prog &&
    !change_protection_gate && (nvm_write && kind == 2'h3 ||
    nvm_read && kind == 2'h2) |=> refused && !busy)
    else $error("ungated software trigger accepted");
  lock_tight_a: assert property (lock_wr && !ext_prog |=>
    (lock_bits & ~$past(lock_bits)) == 12'h000)
    else $error("software loosened a lock");
endmodule

// >>> test/nct_mem_model.sv
// Purpose: Behavioural memory array behind the controller
// Assumes: Request holds until acknowledged
// Notes:   Read word is scrambled outside the acknowledge cycle
module nct_mem_model
  import nct_pkg::*;
#(
  parameter int DLY = 6  // Request to acknowledge takes DLY+1 cycles
)(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rstn,
  // Array port
  input wire logic              mem_req,
  input wire logic [ADDR_W-1:0] mem_addr,
  output logic                  mem_ack,
  output logic [15:0]           mem_rword
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;  // Wait counter, slow answer keeps busy observable

  // Acknowledge once per request after DLY+1 cycles
  always_ff @(posedge clk) begin
    mem_ack <= 1'b0;
    mem_rword <= ~mem_rword;  // No stale value between words
    if (!rstn) begin
      cnt <= 0;
      mem_rword <= 16'h0000;
    end else if (mem_req && !mem_ack) begin
      if (cnt == DLY) begin
        mem_ack <= 1'b1;
        mem_rword <= {8'hC3, mem_addr[7:0]};
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// >>> test/tb_nvm_command_trigger_control.sv
// Purpose: Self-checking bench for the command trigger controller
// Assumes: Inputs change on rising edges by non-blocking writes
// Notes:   Slow memory model keeps each operation busy for a while
module tb_nvm_command_trigger_control;
  import nct_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // Clock, reset and stimulus
  logic clk = 0, rstn = 0, cmd_wr = 0, addr_wr = 0, data_wr = 0;
  logic command_execute_bit = 0, ctrl_b_wr = 0, lock_wr = 0;
  logic ext_prog = 1, change_protection_gate = 0, from_boot = 0;
  logic nvm_read = 0, nvm_write = 0, mem_ack;
  logic [CMD_W-1:0]  cmd_wdata = 0;
  logic [ADDR_W-1:0] addr_wdata = 0, ctrl_b_wdata = 0, mem_addr;
  logic [DATA_W-1:0] data_wdata = 0, mem_wdata;
  logic [11:0]       lock_wdata = 0, lock_bits;
  logic [1:0]        section = 0;
  logic [15:0]       mem_rword;
  // Outputs
  logic mem_req, mem_we, busy, refused, cpu_fetch_ok;
  logic [CMD_W-1:0] cmd_reg;
  logic [CRC_W-1:0] crc_result;
  int mismatches = 0, checked = 0;

  always #25 clk = ~clk;

  nct_controller u_nct_controller (.clk(clk), .rstn(rstn),
    .cmd_wr(cmd_wr), .cmd_wdata(cmd_wdata), .addr_wr(addr_wr),
    .addr_wdata(addr_wdata), .data_wr(data_wr), .data_wdata(data_wdata),
    .command_execute_bit(command_execute_bit), .ctrl_b_wr(ctrl_b_wr),
    .ctrl_b_wdata(ctrl_b_wdata), .lock_wr(lock_wr),
    .lock_wdata(lock_wdata), .ext_prog(ext_prog),
    .change_protection_gate(change_protection_gate),
    .from_boot(from_boot), .section(section), .nvm_read(nvm_read),
    .nvm_write(nvm_write), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rword(mem_rword), .busy(busy), .refused(refused),
    .cpu_fetch_ok(cpu_fetch_ok), .cmd_reg(cmd_reg),
    .crc_result(crc_result), .lock_bits(lock_bits));
  nct_mem_model u_nct_mem_model (.clk(clk), .rstn(rstn),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .mem_rword(mem_rword));

  // Compare one value, four-state exact
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle strobe: k picks register write or trigger
  task automatic put(input int k, input logic [23:0] v);
    @(posedge clk);
    case (k)
      0: begin cmd_wr <= 1'b1; cmd_wdata <= v[6:0]; end
      1: begin addr_wr <= 1'b1; addr_wdata <= v; end
      2: begin data_wr <= 1'b1; data_wdata <= v[7:0]; end
      3: begin ctrl_b_wr <= 1'b1; ctrl_b_wdata <= v; end
      4: begin lock_wr <= 1'b1; lock_wdata <= v[11:0]; end
      5: command_execute_bit <= 1'b1;
      6: nvm_read <= 1'b1;
      default: nvm_write <= 1'b1;
    endcase
    @(posedge clk);
    {cmd_wr, addr_wr, data_wr, ctrl_b_wr, lock_wr} <= 5'h00;
    {command_execute_bit, nvm_read, nvm_write} <= 3'h0;
    #1;
  endtask

  // Bounded wait for completion, counting acknowledges
  task automatic idle(output int acks);
    int n = 0;
    acks = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #1;
      acks += int'(mem_ack === 1'b1);
      n++;
    end
    chk(busy, 0);
  endtask

  task automatic t_write();
    int a;
    put(0, CMD_WRITE_MEM); put(1, 24'h000123); put(2, 24'h5A);
    put(7, 0);
    chk(busy, 1); chk(mem_we, 1); chk(mem_addr, 24'h000123);
    chk(mem_wdata, 8'h5A);
    put(0, CMD_READ_MEM);
    chk(cmd_reg, CMD_WRITE_MEM);
    put(7, 0);
    chk(refused, 1);
    idle(a);
    chk(a, 1);
    $display("test write done");
  endtask

  task automatic t_psig_gate();
    int a;
    put(0, CMD_WRITE_PSIG); put(7, 0);
    chk(refused, 1); chk(busy, 0);
    ext_prog <= 1'b0;
    put(0, CMD_READ_MEM); put(6, 0);
    chk(refused, 1); chk(busy, 0);
    change_protection_gate <= 1'b1;
    put(6, 0);
    chk(busy, 1); chk(mem_we, 0);
    put(6, 0);
    chk(refused, 1);
    idle(a);
    $display("test gate done");
  endtask

  task automatic t_crc();
    int a;
    ext_prog <= 1'b1;
    put(3, 24'h4); put(1, 0); put(0, CMD_CRC_RANGE);
    put(5, 0);
    chk(busy, 1); chk(mem_addr, 0); chk(mem_we, 0);
    idle(a);
    chk(a, 3);
    // Words C300, C302, C304 through the shift-and-feed signature
    chk(crc_result, 24'h024900);
    // Whole flash ignores the address register and starts at zero
    put(3, 24'h2); put(1, 24'h6); put(0, CMD_CRC_FLASH);
    put(5, 0);
    chk(busy, 1); chk(mem_addr, 0);
    idle(a);
    chk(a, 2);
    chk(crc_result, 24'h014502);
    $display("test crc done");
  endtask

  task automatic t_self();
    int a;
    // Boot-resident loader, vector table kept in the boot section
    {ext_prog, from_boot, section} <= {1'b0, 1'b1, SEC_APP};
    put(0, CMD_WRITE_MEM); put(7, 0);
    chk(busy, 1); chk(cpu_fetch_ok, 1);
    idle(a);
    // Writing the boot section stalls fetch; a second write trigger while busy is refused
    section <= SEC_BOOT;
    put(7, 0);
    chk(busy, 1); chk(cpu_fetch_ok, 0);
    put(7, 0);
    chk(refused, 1);
    idle(a);
    section <= SEC_APP;
    put(4, 12'h0F0);
    chk(lock_bits, 12'h0F0);
    put(4, 12'hFFF);
    chk(lock_bits, 12'h0F0);
    // Application write path now closed by its section lock
    put(7, 0);
    chk(refused, 1); chk(busy, 0);
    $display("test self done");
  endtask

  task automatic give_verdict();
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Main sequence: reset values, then scenarios
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(cmd_reg, CMD_NOP); chk(lock_bits, 12'hFFF);
    chk(busy, 0); chk(crc_result, CRC_SEED);
    $display("test reset done");
    t_write(); t_psig_gate(); t_crc(); t_self();
    give_verdict();
  end

  // Watchdog well beyond the roughly 125 cycles needed
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    give_verdict();
  end
endmodule

bind nct_controller nct_props u_nct_props (.clk(clk), .rstn(rstn),
  .cmd_wr(cmd_wr), .command_execute_bit(command_execute_bit),
  .nvm_read(nvm_read), .nvm_write(nvm_write), .lock_wr(lock_wr),
  .ext_prog(ext_prog), .change_protection_gate(change_protection_gate),
  .mem_ack(mem_ack), .busy(busy), .refused(refused),
  .mem_req(mem_req), .cmd_reg(cmd_reg), .lock_bits(lock_bits));
